// File: core/vxcr_pkg.sv
// Package for the configuration register subset: offsets, field layout, constants.
// Assumes a 16-bit register port decoded by the surrounding bus logic.
package vxcr_pkg;
  localparam int          SLOTS         = 13;
  localparam logic [5:0]  OFF_SLOT_SEL  = 6'h08;
  localparam logic [5:0]  OFF_SERIAL_HI = 6'h0A;
  localparam logic [5:0]  OFF_SERIAL_LO = 6'h0C;
  localparam logic [5:0]  OFF_VERSION   = 6'h0E;
  localparam logic [5:0]  OFF_IRQ_STAT  = 6'h1A;
  localparam int          POS_DRIVE_EN  = 13;
  localparam logic [1:0]  SLOT_SEL_TOP  = 2'h3;
  localparam logic [15:0] ATTR_WORD     = 16'hFFF8;
  localparam logic [7:0]  IRQ_CAUSE     = 8'h00;
  localparam logic [12:0] SLOT_RST      = 13'h0000;
  localparam logic        DRIVE_EN_RST  = 1'h0;
  localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
endpackage

// File: core/vxcr_regs.sv
// Slot-select, serial number, version and interrupt status registers.
// Assumes a synchronous single-cycle register port and open-drain-style slot lines
// resolved outside; the slot line inputs are the sampled wire levels.
`timescale 1ns/1ps
// Functional notes
// - Slot-select at 0x08 only in controller slot
// - Thirteen slot lines, one bit each
// - Bit 13 enables slot-line drivers
// - Enabled one drives line high, zero floats
// - Reads return actual sampled line levels
// - Bits 15 and 14 read as ones
// - Offset 0x0A returns serial bits 31-16
// - Offset 0x0C returns serial bits 15-0
// - Serial register writes change nothing
// - Version register read-only, writes ignored
// - Version holds four 4-bit fields
// - Interrupt status presented during acknowledge
// - Status bits 15-8 read zero
// - Status bits 7-0 give logical address
// - Device never raises interrupt request
// - Otherwise 0x08 returns attribute word FFF8
module vxcr_regs
  import vxcr_pkg::*;
#(
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0000,
  parameter logic [3:0]  FW_VERSION    = 4'h1,
  parameter logic [3:0]  FW_REVISION   = 4'h0,
  parameter logic [3:0]  HW_VERSION    = 4'h1,
  parameter logic [3:0]  HW_REVISION   = 4'h0
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              i_controller_slot,
  input  wire logic [7:0]        i_logical_address,
  input  wire logic              i_sel,
  input  wire logic              i_wr,
  input  wire logic [5:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_iack,
  output logic      [15:0]       o_rdata,
  output logic                   o_irq_req,
  input  wire logic [SLOTS-1:0]  i_slot_select_line,
  output logic      [SLOTS-1:0]  o_slot_select_line,
  output logic      [SLOTS-1:0]  o_slot_select_oe_n
);

  // Stored slot-select state; only bits 13..0 exist as flip-flops
  logic [SLOTS-1:0] slot_select_bits;
  logic             slot_select_drive_enable;
  logic [SLOTS-1:0] next_slot_select_bits;
  logic             next_slot_select_drive_enable;
  logic [15:0]      next_rdata;

  // Access qualifiers; an acknowledge cycle outranks a plain read
  logic rd_req;
  logic wr_req;
  logic iack_req;
  assign iack_req = i_iack;
  assign rd_req   = i_sel && !i_wr && !i_iack;
  assign wr_req   = i_sel && i_wr;

  // Offset decode
  logic hit_slot;
  logic hit_serial_hi;
  logic hit_serial_lo;
  logic hit_version;
  logic hit_irq_stat;
  logic hit_any;
  assign hit_slot      = (i_addr == OFF_SLOT_SEL);
  assign hit_serial_hi = (i_addr == OFF_SERIAL_HI);
  assign hit_serial_lo = (i_addr == OFF_SERIAL_LO);
  assign hit_version   = (i_addr == OFF_VERSION);
  assign hit_irq_stat  = (i_addr == OFF_IRQ_STAT);
  assign hit_any       = hit_slot | hit_serial_hi | hit_serial_lo | hit_version | hit_irq_stat;

  // Writes reach storage only in the controller slot; elsewhere 0x08 is read-only
  logic slot_wr;
  logic ro_wr;
  assign slot_wr = wr_req && hit_slot && i_controller_slot;
  // Serial, version and status have no write path; this decode only feeds checks
  assign ro_wr   = wr_req && (hit_serial_hi || hit_serial_lo || hit_version || hit_irq_stat);

  // Bits 15 and 14 of the write word have no storage and fall away here
  assign next_slot_select_bits         = i_wdata[SLOTS-1:0];
  assign next_slot_select_drive_enable = i_wdata[POS_DRIVE_EN];

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      slot_select_bits         <= SLOT_RST;
      slot_select_drive_enable <= DRIVE_EN_RST;
    end else if (slot_wr) begin
      slot_select_bits         <= next_slot_select_bits;
      slot_select_drive_enable <= next_slot_select_drive_enable;
    end
  end

  // Each line is only ever driven high; a zero bit releases it so that the
  // pull-down or another module decides the level
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign o_slot_select_line[g] = 1'b1;
      assign o_slot_select_oe_n[g] = ~(slot_select_drive_enable & slot_select_bits[g]);
    end
  endgenerate

  // Read words. The slot bits come from the wire, not from storage, so a
  // line held high by another module reads back as one
  logic [15:0] slot_word;
  logic [15:0] reg08;
  logic [3:0]  fw_main;
  logic [3:0]  fw_rev;
  logic [3:0]  hw_main;
  logic [3:0]  hw_rev;
  logic [15:0] version;
  logic [15:0] serial_hi;
  logic [15:0] serial_lo;
  logic [15:0] irq_stat;
  assign slot_word = {SLOT_SEL_TOP, slot_select_drive_enable, i_slot_select_line};
  assign reg08     = i_controller_slot ? slot_word : ATTR_WORD;
  assign fw_main   = FW_VERSION;
  assign fw_rev    = FW_REVISION;
  assign hw_main   = HW_VERSION;
  assign hw_rev    = HW_REVISION;
  assign version   = {fw_main, fw_rev, hw_main, hw_rev};
  assign serial_hi = SERIAL_NUMBER[31:16];
  assign serial_lo = SERIAL_NUMBER[15:0];
  // The cause field is tied off: nothing here ever interrupts
  assign irq_stat  = {IRQ_CAUSE, i_logical_address};

  // Read data select; unmapped offsets and idle cycles give zero
  assign next_rdata = iack_req      ? irq_stat      :
                      !rd_req       ? UNMAPPED_WORD :
                      hit_slot      ? reg08         :
                      hit_serial_hi ? serial_hi     :
                      hit_serial_lo ? serial_lo     :
                      hit_version   ? version       :
                      hit_irq_stat  ? irq_stat      :
                                      UNMAPPED_WORD;

  // Registered so the bus sees a clean word one cycle after the request
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_rdata <= UNMAPPED_WORD;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  assign o_irq_req = 1'b0;

  // Cycle counter since reset release, used to check that nothing drives early
  logic [3:0] rst_age;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rst_age <= 4'h0;
    end else if (rst_age != 4'hF) begin
      rst_age <= rst_age + 4'h1;
    end
  end

  a_drive_gated: assert property (@(posedge I_CLK) disable iff (I_RST)
    !slot_select_drive_enable |-> &o_slot_select_oe_n) else $error("slot line driven while disabled");
  a_write_drives: assert property (@(posedge I_CLK) disable iff (I_RST)
    slot_wr && i_wdata[13] && i_wdata[0] |=> !o_slot_select_oe_n[0]) else $error("slot 0 not driven");
  a_slot_readback: assert property (@(posedge I_CLK) disable iff (I_RST)
    i_sel && !i_wr && !i_iack && i_addr == OFF_SLOT_SEL && i_controller_slot
    |=> o_rdata[12:0] == $past(i_slot_select_line) && o_rdata[15:14] == 2'h3)
    else $error("slot readback wrong");
  a_attr_word: assert property (@(posedge I_CLK) disable iff (I_RST)
    i_sel && !i_wr && !i_iack && i_addr == OFF_SLOT_SEL && !i_controller_slot
    |=> o_rdata == 16'hFFF8) else $error("attribute word wrong");
  a_no_wr_attr: assert property (@(posedge I_CLK) disable iff (I_RST)
    i_sel && i_wr && !i_controller_slot |=> $stable(slot_select_bits)
    && $stable(slot_select_drive_enable)) else $error("write leaked in non-controller mode");
  a_serial_hi: assert property (@(posedge I_CLK) disable iff (I_RST)
    i_sel && !i_wr && !i_iack && i_addr == OFF_SERIAL_HI |=> o_rdata == SERIAL_NUMBER[31:16])
    else $error("serial high wrong");
  a_serial_lo: assert property (@(posedge I_CLK) disable iff (I_RST)
    i_sel && !i_wr && !i_iack && i_addr == OFF_SERIAL_LO |=> o_rdata == SERIAL_NUMBER[15:0])
    else $error("serial low wrong");
  a_iack_status: assert property (@(posedge I_CLK) disable iff (I_RST)
    i_iack |=> o_rdata == {8'h00, $past(i_logical_address)}) else $error("status word wrong");
  a_never_irq: assert property (@(posedge I_CLK) o_irq_req == 1'b0)
    else $error("interrupt request raised");
  a_reset_clear: assert property (@(posedge I_CLK) $past(I_RST) && !I_RST |->
    &o_slot_select_oe_n) else $error("line driven after reset");

  c_enable_drive: cover property (@(posedge I_CLK) disable iff (I_RST)
    slot_wr && i_wdata[13] ##1 !(&o_slot_select_oe_n));
  c_attr_read: cover property (@(posedge I_CLK) disable iff (I_RST)
    i_sel && !i_wr && i_addr == OFF_SLOT_SEL && !i_controller_slot);
  c_iack: cover property (@(posedge I_CLK) disable iff (I_RST) i_iack);
  c_serial_read: cover property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && hit_serial_lo);
  c_reset_release: cover property (@(posedge I_CLK)
    $fell(I_RST));

  // Checks on the full write pattern and the released lines
  a_write_pattern: assert property (@(posedge I_CLK) disable iff (I_RST)
    slot_wr && i_wdata[POS_DRIVE_EN] |=> ~o_slot_select_oe_n == $past(i_wdata[SLOTS-1:0]))
    else $error("slot drive pattern wrong");

  a_write_release: assert property (@(posedge I_CLK) disable iff (I_RST)
    slot_wr && !i_wdata[POS_DRIVE_EN] |=> &o_slot_select_oe_n)
    else $error("slot line driven with enable clear");

  a_drive_high: assert property (@(posedge I_CLK)
    &o_slot_select_line)
    else $error("slot line drive value not high");

  a_lines_per_bit: assert property (@(posedge I_CLK) disable iff (I_RST)
    slot_select_drive_enable |-> ~o_slot_select_oe_n == slot_select_bits)
    else $error("slot line not mapped to its bit");

  a_hold_state: assert property (@(posedge I_CLK) disable iff (I_RST)
    !slot_wr |=> $stable(slot_select_bits) && $stable(slot_select_drive_enable))
    else $error("slot state changed without write");

  a_store_discard: assert property (@(posedge I_CLK) disable iff (I_RST)
    slot_wr |=> slot_select_bits == $past(i_wdata[SLOTS-1:0]) && slot_select_drive_enable == $past(i_wdata[13]))
    else $error("slot store wrong");

  // Read-back of the slot-select word
  a_top_ones: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && hit_slot && i_controller_slot |=> o_rdata[15:14] == 2'h3)
    else $error("unused slot bits not ones");

  a_enable_readback: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && hit_slot && i_controller_slot |=> o_rdata[13] == $past(slot_select_drive_enable))
    else $error("drive enable readback wrong");

  a_read_no_side: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req |=> $stable(slot_select_bits) && $stable(slot_select_drive_enable))
    else $error("read changed slot state");

  // Read-only words
  a_serial_wr_inert: assert property (@(posedge I_CLK) disable iff (I_RST)
    ro_wr |=> $stable(slot_select_bits) && $stable(slot_select_drive_enable))
    else $error("read-only write changed state");

  a_version_read: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && hit_version |=> o_rdata == {FW_VERSION, FW_REVISION, HW_VERSION, HW_REVISION})
    else $error("version word wrong");

  a_fw_fields: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && hit_version |=> o_rdata[15:12] == FW_VERSION && o_rdata[3:0] == HW_REVISION)
    else $error("version field placement wrong");

  a_version_wr_inert: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_req && hit_version && !iack_req |=> o_rdata == 16'h0000)
    else $error("version write answered");

  // Status word and acknowledge
  a_cause_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    iack_req |=> o_rdata[15:8] == 8'h00)
    else $error("status cause not zero");

  a_status_read: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && hit_irq_stat |=> o_rdata == {8'h00, $past(i_logical_address)})
    else $error("status read wrong");

  a_iack_priority: assert property (@(posedge I_CLK) disable iff (I_RST)
    iack_req && i_sel && !i_wr |=> o_rdata == {8'h00, $past(i_logical_address)})
    else $error("acknowledge lost to read");

  // Idle, unmapped and reset behaviour
  a_unmapped_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_req && !hit_any |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_idle_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    !i_sel && !iack_req |=> o_rdata == 16'h0000)
    else $error("idle read data not zero");

  a_write_no_data: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_req && !iack_req |=> o_rdata == 16'h0000)
    else $error("write answered with data");

  a_reset_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
    rst_age == 4'h0 |-> &o_slot_select_oe_n && o_rdata == 16'h0000)
    else $error("state not clear after reset");

endmodule

// File: verification/vxcr_slot_bus.sv
// Model of the shared slot-select wires in the chassis.
// Assumes each wire has a pull-down and that other modules can only pull a wire high.
`timescale 1ns/1ps
module vxcr_slot_bus (
  input  wire logic [12:0] i_oe_n,
  input  wire logic [12:0] i_drive,
  input  wire logic [12:0] i_ext,
  output logic      [12:0] o_line
);
  // An undriven wire settles low through its pull-down, never at its last value
  assign o_line = (i_drive & ~i_oe_n) | i_ext;
endmodule

// File: verification/tb.sv
// Self-checking bench for the configuration register subset.
// Assumes the one-cycle registered read answer described for the register port.
`timescale 1ns/1ps
module tb;
  import vxcr_pkg::*;
  logic        I_CLK = 0, I_RST = 1, strap = 1, sel = 0, wr = 0, iack = 0;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic [7:0]  la = 8'h5A;
  logic [12:0] ext = 13'h0000;
  wire  [15:0] rdata;
  wire         irq;
  wire  [12:0] line, drv, oe_n;
  int          miscompares = 0, num_checks = 0;
  always #12.5 I_CLK = ~I_CLK;
  vxcr_regs #(.SERIAL_NUMBER(32'hA5C3_1E07), .FW_VERSION(4'h9), .FW_REVISION(4'h6),
    .HW_VERSION(4'h3), .HW_REVISION(4'hC)) dut (.I_CLK(I_CLK), .I_RST(I_RST),
    .i_controller_slot(strap), .i_logical_address(la), .i_sel(sel), .i_wr(wr),
    .i_addr(addr), .i_wdata(wdata), .i_iack(iack), .o_rdata(rdata), .o_irq_req(irq),
    .i_slot_select_line(line), .o_slot_select_line(drv), .o_slot_select_oe_n(oe_n));
  vxcr_slot_bus bus (.i_oe_n(oe_n), .i_drive(drv), .i_ext(ext), .o_line(line));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One access per call, launched and judged on falling edges
  task automatic acc(input logic w, k, input logic [5:0] a, input logic [15:0] d, e);
    sel = ~k;
    iack = k;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge I_CLK);
    if (!w) chk(rdata, e);
    sel = 0;
    iack = 0;
    @(negedge I_CLK);
  endtask
  task automatic t_reset;
    acc(1, 0, OFF_SLOT_SEL, 16'h2001, 16'h0000);
    chk({3'h0, oe_n}, 16'h1FFE);
    I_RST = 1;
    repeat (2) @(negedge I_CLK);
    I_RST = 0;
    chk({3'h0, oe_n}, 16'h1FFF);
    chk(rdata, 16'h0000);
    acc(0, 0, OFF_SLOT_SEL, 16'h0000, 16'hC000);
  endtask
  task automatic t_slot;
    chk({3'h0, oe_n}, 16'h1FFF);
    acc(0, 0, OFF_SLOT_SEL, 16'h0000, 16'hC000);
    acc(1, 0, OFF_SLOT_SEL, 16'hE001, 16'h0000);
    chk({3'h0, oe_n}, 16'h1FFE);
    ext = 13'h0020;
    acc(0, 0, OFF_SLOT_SEL, 16'h0000, 16'hE021);
    acc(1, 0, OFF_SLOT_SEL, 16'hC003, 16'h0000);
    acc(0, 0, OFF_SLOT_SEL, 16'h0000, 16'hC020);
    ext = 13'h0000;
  endtask
  task automatic t_ro;
    acc(1, 0, OFF_SERIAL_HI, 16'hFFFF, 16'h0000);
    acc(0, 0, OFF_SERIAL_HI, 16'h0000, 16'hA5C3);
    acc(1, 0, OFF_SERIAL_LO, 16'h0000, 16'h0000);
    acc(0, 0, OFF_SERIAL_LO, 16'h0000, 16'h1E07);
    acc(1, 0, OFF_VERSION, 16'h0000, 16'h0000);
    acc(0, 0, OFF_VERSION, 16'h0000, 16'h963C);
    acc(0, 1, OFF_IRQ_STAT, 16'h0000, 16'h005A);
    acc(0, 0, 6'h10, 16'h0000, UNMAPPED_WORD);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_attr;
    strap = 0;
    acc(1, 0, OFF_SLOT_SEL, 16'h2FFF, 16'h0000);
    acc(0, 0, OFF_SLOT_SEL, 16'h0000, 16'hFFF8);
    chk({3'h0, oe_n}, 16'h1FFF);
    strap = 1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge I_CLK);
    I_RST = 0;
    t_slot();
    t_ro();
    t_attr();
    t_reset();
    final_report();
  end
endmodule
